// *** rtl/swl_engine_regs.v ***
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs_map.vh"

module swl_engine_regs
(
   input wire clk_i,
   input wire nrst_i,
   input wire [14:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire [2:0] learn_discard_i,
   input wire drop_i,
   input wire [1:0] drop_port_i,
   input wire da_known_i,
   input wire da_bcast_i,
   input wire da_mcast_i,
   input wire admit_tagged_only_i,
   input wire pkt_tagged_i,
   input wire vid_all_ones_i,
   input wire member_check_i,
   input wire admit_nonmember_i,
   input wire src_member_i,
   input wire dst_member_i,
   input wire src_fwd_i,
   input wire dst_fwd_i,
   input wire drop_unknown_i,
   input wire filter_mcast_i,
   input wire bcast_throttled_i,
   input wire same_port_i,
   input wire entry_filter_i,
   output reg engine_irq_o
);

   // ----------------------------------------------------------------
   // Bus access
   // ----------------------------------------------------------------
   wire acc_go;
   wire rd_go;
   wire wr_go;
   wire [12:0] word_idx;
   wire sel_cnt0;
   wire sel_cnt1;
   wire sel_cnt2;
   wire sel_mask;
   wire sel_status;
   wire [2:0] cnt_clr;
   wire [31:0] cnt_val [0:2];

   // A request is taken only while waitrequest is high, so a held
   // request is never acted on twice.
   assign acc_go = (avs_read_i || avs_write_i) && avs_waitrequest_o;
   assign rd_go = acc_go && avs_read_i;
   assign wr_go = acc_go && avs_write_i;
   assign word_idx = avs_address_i[14:2];
   assign sel_cnt0 = (word_idx == `SWL_IDX_CNT0);
   assign sel_cnt1 = (word_idx == `SWL_IDX_CNT1);
   assign sel_cnt2 = (word_idx == `SWL_IDX_CNT2);
   assign sel_mask = (word_idx == `SWL_IDX_MASK);
   assign sel_status = (word_idx == `SWL_IDX_STATUS);
   assign cnt_clr = {rd_go && sel_cnt2, rd_go && sel_cnt1, rd_go && sel_cnt0};

   // ----------------------------------------------------------------
   // Learn-discard counters
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_cnt
         swl_sat_counter u_cnt
         (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .inc_i(learn_discard_i[gi]),
            .clr_i(cnt_clr[gi]),
            .cnt_o(cnt_val[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Drop classification
   // ----------------------------------------------------------------
   wire [3:0] cls_reason;
   wire cls_match;
   wire rec;

   swl_drop_classify u_cls
   (
      .da_known_i(da_known_i),
      .da_bcast_i(da_bcast_i),
      .da_mcast_i(da_mcast_i),
      .admit_tagged_only_i(admit_tagged_only_i),
      .pkt_tagged_i(pkt_tagged_i),
      .vid_all_ones_i(vid_all_ones_i),
      .member_check_i(member_check_i),
      .admit_nonmember_i(admit_nonmember_i),
      .src_member_i(src_member_i),
      .dst_member_i(dst_member_i),
      .src_fwd_i(src_fwd_i),
      .dst_fwd_i(dst_fwd_i),
      .drop_unknown_i(drop_unknown_i),
      .filter_mcast_i(filter_mcast_i),
      .bcast_throttled_i(bcast_throttled_i),
      .same_port_i(same_port_i),
      .entry_filter_i(entry_filter_i),
      .reason_o(cls_reason),
      .match_o(cls_match)
   );

   // A reserved source port is never recorded.
   assign rec = drop_i && cls_match && (drop_port_i != 2'h3);

   // ----------------------------------------------------------------
   // Mask and status registers
   // ----------------------------------------------------------------
   reg mask_reg;
   reg mask_next;
   reg pend_reg;
   reg pend_next;
   reg a_valid_reg;
   reg a_valid_next;
   reg [1:0] a_port_reg;
   reg [1:0] a_port_next;
   reg [3:0] a_rsn_reg;
   reg [3:0] a_rsn_next;
   reg b_valid_reg;
   reg b_valid_next;
   reg [1:0] b_port_reg;
   reg [1:0] b_port_next;
   reg [3:0] b_rsn_reg;
   reg [3:0] b_rsn_next;
   wire st_clr;
   wire [31:0] status_word;

   assign st_clr = rd_go && sel_status;

   assign status_word = {17'h00000, b_rsn_reg, b_port_reg, b_valid_reg,
                         a_rsn_reg, a_port_reg, a_valid_reg, pend_reg};

   always @*
   begin
      mask_next = mask_reg;
      if (wr_go && sel_mask && avs_byteenable_i[0])
      begin
         mask_next = avs_writedata_i[`SWL_MASK_BIT];
      end
   end

   // A drop in the cycle of a status read lands after the clear, so
   // it is never lost. With both records full a third drop only
   // keeps the pending bit set.
   always @*
   begin
      a_valid_next = a_valid_reg;
      a_port_next = a_port_reg;
      a_rsn_next = a_rsn_reg;
      b_valid_next = b_valid_reg;
      b_port_next = b_port_reg;
      b_rsn_next = b_rsn_reg;
      pend_next = pend_reg;
      if (st_clr)
      begin
         pend_next = 1'b0;
         a_valid_next = 1'b0;
         a_port_next = 2'h0;
         a_rsn_next = 4'h0;
         b_valid_next = 1'b0;
         b_port_next = 2'h0;
         b_rsn_next = 4'h0;
      end
      if (rec)
      begin
         pend_next = 1'b1;
         if (!a_valid_next)
         begin
            a_valid_next = 1'b1;
            a_port_next = drop_port_i;
            a_rsn_next = cls_reason;
         end
         else if (!b_valid_next)
         begin
            b_valid_next = 1'b1;
            b_port_next = drop_port_i;
            b_rsn_next = cls_reason;
         end
      end
   end

   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mask_reg <= `SWL_RST_MASK;
         pend_reg <= 1'b0;
         a_valid_reg <= 1'b0;
         a_port_reg <= 2'h0;
         a_rsn_reg <= 4'h0;
         b_valid_reg <= 1'b0;
         b_port_reg <= 2'h0;
         b_rsn_reg <= 4'h0;
      end
      else
      begin
         mask_reg <= mask_next;
         pend_reg <= pend_next;
         a_valid_reg <= a_valid_next;
         a_port_reg <= a_port_next;
         a_rsn_reg <= a_rsn_next;
         b_valid_reg <= b_valid_next;
         b_port_reg <= b_port_next;
         b_rsn_reg <= b_rsn_next;
      end
   end

   // ----------------------------------------------------------------
   // Read data and handshake
   // ----------------------------------------------------------------
   reg [31:0] rd_mux;

   always @*
   begin
      rd_mux = 32'h00000000;
      if (sel_cnt0)
         rd_mux = cnt_val[0];
      else if (sel_cnt1)
         rd_mux = cnt_val[1];
      else if (sel_cnt2)
         rd_mux = cnt_val[2];
      else if (sel_mask)
         rd_mux = {31'h00000000, mask_reg};
      else if (sel_status)
         rd_mux = status_word;
   end

   // Every access answers one edge after it is taken: waitrequest
   // falls for exactly one cycle with the read data beside it.
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
      end
      else
      begin
         avs_waitrequest_o <= !acc_go;
         if (rd_go)
         begin
            avs_readdata_o <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   // The request follows the next-state values, so a drop, a status
   // read or a mask write shows on the request at the same edge.
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         engine_irq_o <= 1'b0;
      end
      else
      begin
         engine_irq_o <= pend_next && !mask_next;
      end
   end

endmodule
`default_nettype wire

// *** rtl/swl_regs_map.vh ***
`ifndef SWL_REGS_MAP_VH
`define SWL_REGS_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SWL_IDX_CNT0 13'h1858
`define SWL_IDX_CNT1 13'h1859
`define SWL_IDX_CNT2 13'h185A
`define SWL_IDX_MASK 13'h1880
`define SWL_IDX_STATUS 13'h1881

// ----------------------------------------------------------------
// Reset values and counter saturation limit
// ----------------------------------------------------------------
`define SWL_RST_CNT 32'h00000000
`define SWL_RST_MASK 1'h1
`define SWL_CNT_MAX 32'hFFFFFFFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SWL_MASK_BIT 0
`define SWL_ST_PEND 0
`define SWL_ST_A_VALID 1
`define SWL_ST_A_PORT_LO 2
`define SWL_ST_A_PORT_HI 3
`define SWL_ST_A_RSN_LO 4
`define SWL_ST_A_RSN_HI 7
`define SWL_ST_B_VALID 8
`define SWL_ST_B_PORT_LO 9
`define SWL_ST_B_PORT_HI 10
`define SWL_ST_B_RSN_LO 11
`define SWL_ST_B_RSN_HI 14

// ----------------------------------------------------------------
// Drop reason codes
// ----------------------------------------------------------------
`define SWL_RSN_UNTAGGED 4'h0
`define SWL_RSN_UNK_SRC_NONMEMBER 4'h1
`define SWL_RSN_SRC_NOT_FWD 4'h2
`define SWL_RSN_DST_NOT_FWD 4'h3
`define SWL_RSN_DST_NONMEMBER 4'h4
`define SWL_RSN_SRC_NONMEMBER 4'h5
`define SWL_RSN_UNK_UNICAST 4'h6
`define SWL_RSN_UNK_MULTICAST 4'h7
`define SWL_RSN_BCAST_THROTTLE 4'h8
`define SWL_RSN_UNK_SRC_NOT_FWD 4'h9
`define SWL_RSN_SAME_PORT 4'hA
`define SWL_RSN_ENTRY_FILTER 4'hB
`define SWL_RSN_VID_ALL_ONES 4'hE

`endif

// *** rtl/swl_sat_counter.v ***
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs_map.vh"

module swl_sat_counter
(
   input wire clk_i,
   input wire nrst_i,
   input wire inc_i,
   input wire clr_i,
   output reg [31:0] cnt_o
);

   reg [31:0] cnt_next;

   // An increment in the clearing cycle survives as a count of one.
   always @*
   begin
      cnt_next = cnt_o;
      if (clr_i)
      begin
         cnt_next = inc_i ? 32'h00000001 : `SWL_RST_CNT;
      end
      else if (inc_i && (cnt_o != `SWL_CNT_MAX))
      begin
         cnt_next = cnt_o + 32'h00000001;
      end
   end

   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_o <= `SWL_RST_CNT;
      end
      else
      begin
         cnt_o <= cnt_next;
      end
   end

endmodule
`default_nettype wire

// *** rtl/swl_drop_classify.v ***
`timescale 1ns/1ps
`default_nettype none
`include "swl_regs_map.vh"

module swl_drop_classify
(
   input wire da_known_i,
   input wire da_bcast_i,
   input wire da_mcast_i,
   input wire admit_tagged_only_i,
   input wire pkt_tagged_i,
   input wire vid_all_ones_i,
   input wire member_check_i,
   input wire admit_nonmember_i,
   input wire src_member_i,
   input wire dst_member_i,
   input wire src_fwd_i,
   input wire dst_fwd_i,
   input wire drop_unknown_i,
   input wire filter_mcast_i,
   input wire bcast_throttled_i,
   input wire same_port_i,
   input wire entry_filter_i,
   output reg [3:0] reason_o,
   output reg match_o
);

   // Checks are taken in a fixed order; reserved codes are never chosen.
   always @*
   begin
      reason_o = `SWL_RSN_UNTAGGED;
      match_o = 1'b1;
      if (vid_all_ones_i)
         reason_o = `SWL_RSN_VID_ALL_ONES;
      else if (admit_tagged_only_i && !pkt_tagged_i)
         reason_o = `SWL_RSN_UNTAGGED;
      else if (!da_known_i)
      begin
         if (!src_fwd_i)
            reason_o = `SWL_RSN_UNK_SRC_NOT_FWD;
         else if (da_bcast_i && bcast_throttled_i)
            reason_o = `SWL_RSN_BCAST_THROTTLE;
         else if (member_check_i && !admit_nonmember_i && !src_member_i)
            reason_o = `SWL_RSN_UNK_SRC_NONMEMBER;
         else if (drop_unknown_i && !da_bcast_i && !da_mcast_i)
            reason_o = `SWL_RSN_UNK_UNICAST;
         else if (filter_mcast_i && da_mcast_i && !da_bcast_i)
            reason_o = `SWL_RSN_UNK_MULTICAST;
         else
            match_o = 1'b0;
      end
      else
      begin
         if (!src_fwd_i)
            reason_o = `SWL_RSN_SRC_NOT_FWD;
         else if (!dst_fwd_i)
            reason_o = `SWL_RSN_DST_NOT_FWD;
         else if (member_check_i && !dst_member_i)
            reason_o = `SWL_RSN_DST_NONMEMBER;
         else if (member_check_i && !admit_nonmember_i && !src_member_i)
            reason_o = `SWL_RSN_SRC_NONMEMBER;
         else if (same_port_i)
            reason_o = `SWL_RSN_SAME_PORT;
         else if (entry_filter_i)
            reason_o = `SWL_RSN_ENTRY_FILTER;
         else
            match_o = 1'b0;
      end
   end

endmodule
`default_nettype wire

// *** sim/swl_engine_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module swl_engine_regs_chk
(
   input wire clk_i,
   input wire nrst_i,
   input wire [14:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire [2:0] learn_discard_i,
   input wire drop_i,
   input wire engine_irq_o
);
   // ----------------
   // Helpers
   // ----------------
   wire [12:0] idx = avs_address_i[14:2];
   wire rd_go = avs_read_i & avs_waitrequest_o;
   wire mwr = avs_write_i & avs_waitrequest_o & (idx == 13'h1880) & avs_byteenable_i[0];
   reg mask_reg;
   // Mirror of the mask bit as written over the bus.
   always @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
         mask_reg <= 1'b1;
      else if (mwr)
         mask_reg <= avs_writedata_i[0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence st_clr;
      rd_go && idx == 13'h1881 && !drop_i;
   endsequence
   sequence c0_clr;
      rd_go && idx == 13'h1858 && !learn_discard_i[0];
   endsequence
   // ----------------
   // Properties
   // ----------------
   wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing wrong");
   resv_zero_a: assert property (rd_go && idx == 13'h1881 |=> avs_readdata_o[31:15] == 17'h0)
      else $error("status reserved bits set");
   pend_flag_a: assert property (rd_go && idx == 13'h1881 |=>
      avs_readdata_o[0] == avs_readdata_o[1]) else $error("pending bit wrong");
   rsn_code_a: assert property (rd_go && idx == 13'h1881 |=>
      (avs_readdata_o[7:6] != 2'h3 || avs_readdata_o[5:4] == 2'h2) &&
      (avs_readdata_o[14:13] != 2'h3 || avs_readdata_o[12:11] == 2'h2)) else $error("bad reason");
   stat_clear_a: assert property (st_clr ##1 (!drop_i) [*2] ##1 st_clr |=>
      avs_readdata_o == 32'h0) else $error("status not cleared");
   cnt_clear_a: assert property (c0_clr ##1 (!learn_discard_i[0]) [*2] ##1 c0_clr |=>
      avs_readdata_o == 32'h0) else $error("counter not cleared");
   mask_quiet_a: assert property (mask_reg |-> !engine_irq_o)
      else $error("irq while masked");
   irq_rise_a: assert property ($rose(engine_irq_o) |-> $past(drop_i) || $past(mwr))
      else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(engine_irq_o) |-> $past(rd_go) || $past(mwr))
      else $error("irq fell without cause");
endmodule
bind swl_engine_regs swl_engine_regs_chk u_chk (.clk_i, .nrst_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
   .learn_discard_i, .drop_i, .engine_irq_o);
`default_nettype wire

// *** sim/swl_engine_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("ERROR %s exp %h got %h", n, e, g); \
      end \
   end
module swl_engine_regs_bench;
   logic clk_i = 1'b0;
   logic nrst_i, avs_read_i, avs_write_i, drop_i, avs_waitrequest_o, engine_irq_o;
   logic [14:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [3:0] avs_byteenable_i;
   logic [2:0] learn_discard_i;
   logic [1:0] drop_port_i;
   logic [16:0] flg;
   integer error_cnt = 0;
   integer tests_run = 0;
   localparam logic [16:0] FL [0:12] = '{17'h00F08, 17'h00E52, 17'h00B11, 17'h00711,
      17'h00D51, 17'h00E51, 17'h01F10, 17'h02F14, 17'h04F12, 17'h00B12, 17'h08F11,
      17'h10F11, 17'h00F30};
   always #4 clk_i = ~clk_i;
   swl_engine_regs DUT (.clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .learn_discard_i, .drop_i, .drop_port_i, .da_known_i(flg[0]), .da_bcast_i(flg[1]),
      .da_mcast_i(flg[2]), .admit_tagged_only_i(flg[3]), .pkt_tagged_i(flg[4]),
      .vid_all_ones_i(flg[5]), .member_check_i(flg[6]), .admit_nonmember_i(flg[7]),
      .src_member_i(flg[8]), .dst_member_i(flg[9]), .src_fwd_i(flg[10]), .dst_fwd_i(flg[11]),
      .drop_unknown_i(flg[12]), .filter_mcast_i(flg[13]), .bcast_throttled_i(flg[14]),
      .same_port_i(flg[15]), .entry_filter_i(flg[16]), .engine_irq_o);
   // ----------------
   // Bus and event tasks
   // ----------------
   task report_and_stop;
      begin
         if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task automatic acc(input bit wr, input [12:0] idx, input [31:0] wd, input [3:0] be);
      integer n;
      begin
         avs_address_i <= {idx, 2'h0};
         avs_read_i <= !wr;
         avs_write_i <= wr;
         avs_writedata_i <= wd;
         avs_byteenable_i <= be;
         n = 0;
         do
         begin
            @(posedge clk_i);
            n++;
         end
         while (avs_waitrequest_o !== 1'b0 && n < 20);
         if (n >= 20)
         begin
            error_cnt++;
            report_and_stop;
         end
         else
         begin
            rd = avs_readdata_o;
            avs_read_i <= 1'b0;
            avs_write_i <= 1'b0;
            @(posedge clk_i);
         end
      end
   endtask
   task automatic rdr(input [12:0] idx);
      acc(1'b0, idx, 32'h0, 4'hF);
   endtask
   task automatic drop(input [16:0] f, input [1:0] p);
      begin
         flg <= f;
         drop_port_i <= p;
         drop_i <= 1'b1;
         @(posedge clk_i);
         drop_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   function automatic [5:0] rec(input integer i);
      integer m;
      begin
         m = i % 3;
         rec = {((i < 12) ? i[3:0] : 4'hE), m[1:0]};
      end
   endfunction
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_reset;
      integer i;
      begin
         rdr(13'h1880);
         `CHK("mask", 32'h1, rd)
         rdr(13'h1881);
         `CHK("status", 32'h0, rd)
         for (i = 0; i < 3; i++)
         begin
            rdr(13'h1858 + i[12:0]);
            `CHK("cnt rst", 32'h0, rd)
         end
         `CHK("irq rst", 1'b0, engine_irq_o)
      end
   endtask
   task automatic t_count;
      begin
         learn_discard_i <= 3'h7;
         @(posedge clk_i);
         learn_discard_i <= 3'h1;
         @(posedge clk_i);
         learn_discard_i <= 3'h5;
         @(posedge clk_i);
         learn_discard_i <= 3'h0;
         @(posedge clk_i);
         acc(1'b1, 13'h1859, 32'h0000FFFF, 4'hF);
         rdr(13'h1858);
         `CHK("cnt0", 32'h3, rd)
         rdr(13'h1858);
         `CHK("cnt0 clr", 32'h0, rd)
         rdr(13'h1859);
         `CHK("cnt1", 32'h1, rd)
         rdr(13'h185A);
         `CHK("cnt2", 32'h2, rd)
         rdr(13'h1882);
         `CHK("unmapped", 32'h0, rd)
      end
   endtask
   task automatic t_mask;
      begin
         drop(FL[12], 2'h1);
         `CHK("irq masked", 1'b0, engine_irq_o)
         acc(1'b1, 13'h1880, 32'h0, 4'hF);
         `CHK("irq open", 1'b1, engine_irq_o)
         acc(1'b1, 13'h1880, 32'h1, 4'hE);
         rdr(13'h1880);
         `CHK("mask lane", 32'h0, rd)
         acc(1'b1, 13'h1880, 32'hFFFFFFFF, 4'hF);
         `CHK("irq shut", 1'b0, engine_irq_o)
         rdr(13'h1881);
         `CHK("status kept", 32'h000000E7, rd)
         acc(1'b1, 13'h1880, 32'h0, 4'h1);
         drop(FL[3], 2'h0);
         `CHK("irq drop", 1'b1, engine_irq_o)
         rdr(13'h1881);
         `CHK("status one", 32'h00000033, rd)
         `CHK("irq clr", 1'b0, engine_irq_o)
      end
   endtask
   task automatic t_codes;
      integer i;
      logic [31:0] e;
      begin
         for (i = 0; i < 13; i = i + 2)
         begin
            drop(FL[i], 2'(i % 3));
            e = {24'h0, rec(i), 2'h3};
            if (i < 12)
            begin
               drop(FL[i + 1], 2'((i + 1) % 3));
               drop(FL[0], 2'h2);
               e = {17'h0, rec(i + 1), 1'b1, rec(i), 2'h3};
            end
            rdr(13'h1881);
            `CHK("drop record", e, rd)
         end
         rdr(13'h1881);
         `CHK("status clr", 32'h0, rd)
         drop(FL[0], 2'h3);
         drop(17'h00F10, 2'h0);
         rdr(13'h1881);
         `CHK("no record", 32'h0, rd)
      end
   endtask
   initial
   begin
      nrst_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 15'h0;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'h0;
      learn_discard_i = 3'h0;
      drop_i = 1'b0;
      drop_port_i = 2'h0;
      flg = 17'h00F10;
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      t_reset;
      t_count;
      t_mask;
      t_codes;
      report_and_stop;
   end
endmodule
`default_nettype wire
